/* File: rtl/ivob_pkg.sv */
`default_nettype none
package ivob_pkg;

    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    // Sources and displacement bank size
    localparam int NSRC = 16;
    localparam int NDISP = 14;

    // Interrupt register bases, each with three alias words above it
    localparam logic [ADDR_W-1:0] OFF_FLAG = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_ENAB = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_STAT = 12'h020;
    localparam logic [ADDR_W-1:0] OFF_MASK = 12'h030;

    // Alias selected by address bits 3:2 (base, +0x4, +0x8, +0xc)
    localparam logic [1:0] ALIAS_DIR = 2'h0;
    localparam logic [1:0] ALIAS_CLR = 2'h1;
    localparam logic [1:0] ALIAS_SET = 2'h2;
    localparam logic [1:0] ALIAS_INV = 2'h3;

    // Vector displacement register offsets, sources 41..50 and 53..56
    localparam logic [ADDR_W-1:0] DISP_OFF [NDISP] = '{
        12'h5e4, 12'h5e8, 12'h5ec, 12'h5f0, 12'h5f4, 12'h5f8, 12'h5fc,
        12'h600, 12'h604, 12'h608, 12'h614, 12'h618, 12'h61c, 12'h620
    };

    // Displacement field layout and reset values
    localparam int DISP_LSB = 1;
    localparam int DISP_MSB = 17;
    localparam int DISP_W = DISP_MSB - DISP_LSB + 1;
    localparam logic [DISP_W-1:0] DISP_RST = 17'h00000;
    localparam logic [NSRC-1:0] FLAG_RST = 16'h0000;
    localparam logic [NSRC-1:0] ENAB_RST = 16'h0000;
    localparam logic [NSRC-1:0] STAT_RST = 16'h0000;
    localparam logic [NSRC-1:0] MASK_RST = 16'h0000;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Decoded register kinds
    localparam logic [2:0] REG_NONE = 3'h0;
    localparam logic [2:0] REG_FLAG = 3'h1;
    localparam logic [2:0] REG_ENAB = 3'h2;
    localparam logic [2:0] REG_STAT = 3'h3;
    localparam logic [2:0] REG_MASK = 3'h4;
    localparam logic [2:0] REG_DISP = 3'h5;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [DATA_W-1:0] wdata;
        logic [STRB_W-1:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } ivob_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } ivob_axi_rsp_t;

    typedef struct packed {
        logic [2:0] kind;
        logic [1:0] op;
        logic [3:0] idx;
    } ivob_dec_t;

endpackage : ivob_pkg

`default_nettype wire

/* File: rtl/ivob_alias_reg.sv */
`timescale 1ns/10ps
`default_nettype none

module ivob_alias_reg #(
    parameter int W = 16,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic wr_i,
    input wire logic [1:0] op_i,
    input wire logic [W-1:0] wdata_i,
    input wire logic [W-1:0] wmask_i,
    input wire logic [W-1:0] hw_set_i,
    output logic [W-1:0] q_o
);
    import ivob_pkg::*;

    logic [W-1:0] bits;
    logic [W-1:0] next_q;

    // Direct write or clear/set/toggle alias, hardware set wins
    always_comb begin
        bits = wdata_i & wmask_i;
        next_q = q_o;
        if (wr_i) begin
            unique case (op_i)
                ALIAS_DIR: next_q = (q_o & ~wmask_i) | bits;
                ALIAS_CLR: next_q = q_o & ~bits;
                ALIAS_SET: next_q = q_o | bits;
                ALIAS_INV: next_q = q_o ^ bits;
            endcase
        end
        next_q = next_q | hw_set_i;
    end

    // Storage
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q_o <= RST;
        end else begin
            q_o <= next_q;
        end
    end

endmodule : ivob_alias_reg

`default_nettype wire

/* File: rtl/ivob_bank.sv */
// Function
// - Interrupt registers get clear, set and toggle aliases at base plus 4, 8, c.
// - Displacement registers have no aliases; only direct writes update them.
// - A flag sets when its peripheral is enabled and its event occurs.
// - Flag setting ignores the interrupt enable bit of that source.
// - Flags are always readable so software can poll them.
// - A set flag stays set until software clears it.
// - Unimplemented bits ignore writes and read as zero.
`timescale 1ns/10ps
`default_nettype none

module ivob_bank (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire ivob_pkg::ivob_axi_req_t axi_req_i,
    output ivob_pkg::ivob_axi_rsp_t axi_rsp_o,
    input wire logic [ivob_pkg::NSRC-1:0] src_evt_i,
    input wire logic [ivob_pkg::NSRC-1:0] periph_en_i,
    input wire logic [3:0] disp_sel_i,
    output logic [ivob_pkg::DATA_W-1:0] disp_off_o,
    output logic [ivob_pkg::NSRC-1:0] int_flag_o,
    output logic irq_o
);
    import ivob_pkg::*;

    // Write channel state
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_hold;
    logic w_hold;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] w_data;
    logic [STRB_W-1:0] w_strb;

    // Read channel state
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic ar_hold;
    logic [ADDR_W-1:0] ar_addr;

    // Register contents
    logic [NSRC-1:0] int_enab;
    logic [NSRC-1:0] irq_stat;
    logic [NSRC-1:0] irq_mask;
    logic [DISP_W-1:0] disp [NDISP];

    // Decode and strobes
    ivob_dec_t wr_dec;
    ivob_dec_t rd_dec;
    logic wr_go;
    logic rd_go;
    logic [DATA_W-1:0] wmask;
    logic [DATA_W-1:0] rd_mux;
    logic [NSRC-1:0] flag_set;
    logic [NSRC-1:0] stat_set;
    logic [NSRC-1:0] stat_clr;
    logic wr_flag;
    logic wr_enab;
    logic wr_mask;
    logic wr_stat;
    logic [NSRC-1:0] stat_bits;
    logic [NSRC-1:0] next_stat;

    // Address to register kind, alias and displacement index
    function automatic ivob_dec_t decode(input logic [ADDR_W-1:0] a);
        ivob_dec_t d;
        logic [ADDR_W-1:0] base;
        d.kind = REG_NONE;
        d.op = a[3:2];
        d.idx = 4'h0;
        base = {a[ADDR_W-1:4], 4'h0};
        if (base == OFF_FLAG) begin
            d.kind = REG_FLAG;
        end else if (base == OFF_ENAB) begin
            d.kind = REG_ENAB;
        end else if (base == OFF_MASK) begin
            d.kind = REG_MASK;
        end else if (base == OFF_STAT) begin
            d.kind = REG_STAT;
        end
        // Displacement words match only their exact word address
        for (int i = 0; i < NDISP; i++) begin
            if (a[ADDR_W-1:2] == DISP_OFF[i][ADDR_W-1:2]) begin
                d.kind = REG_DISP;
                d.op = ALIAS_DIR;
                d.idx = 4'(i);
            end
        end
        return d;
    endfunction : decode

    assign wr_dec = decode(aw_addr);
    assign rd_dec = decode(ar_addr);

    // Commit strobes once the write address and data, or the read address, are held
    assign wr_go = aw_hold && w_hold && !bvalid;
    assign rd_go = ar_hold && !rvalid;

    // Byte strobes widened to a bit mask
    always_comb begin
        for (int b = 0; b < STRB_W; b++) begin
            wmask[b*8 +: 8] = {8{w_strb[b]}};
        end
    end

    // Write address channel
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            awready <= 1'b0;
            aw_hold <= 1'b0;
            aw_addr <= '0;
        end else begin
            if (axi_req_i.awvalid && awready) begin
                awready <= 1'b0;
                aw_hold <= 1'b1;
                aw_addr <= axi_req_i.awaddr;
            end else if (wr_go) begin
                aw_hold <= 1'b0;
            end else if (!aw_hold && !bvalid) begin
                awready <= 1'b1;
            end
        end
    end

    // Write data channel
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wready <= 1'b0;
            w_hold <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else begin
            if (axi_req_i.wvalid && wready) begin
                wready <= 1'b0;
                w_hold <= 1'b1;
                w_data <= axi_req_i.wdata;
                w_strb <= axi_req_i.wstrb;
            end else if (wr_go) begin
                w_hold <= 1'b0;
            end else if (!w_hold && !bvalid) begin
                wready <= 1'b1;
            end
        end
    end

    // Write response, error on an unmapped word
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp <= (wr_dec.kind == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (bvalid && axi_req_i.bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Read address channel
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            arready <= 1'b0;
            ar_hold <= 1'b0;
            ar_addr <= '0;
        end else begin
            if (axi_req_i.arvalid && arready) begin
                arready <= 1'b0;
                ar_hold <= 1'b1;
                ar_addr <= axi_req_i.araddr;
            end else if (rd_go) begin
                ar_hold <= 1'b0;
            end else if (!ar_hold && !rvalid) begin
                arready <= 1'b1;
            end
        end
    end

    // Read data select, unimplemented bits zero
    always_comb begin
        rd_mux = '0;
        unique case (rd_dec.kind)
            REG_FLAG: rd_mux = DATA_W'(int_flag_o);
            REG_ENAB: rd_mux = DATA_W'(int_enab);
            REG_STAT: rd_mux = DATA_W'(irq_stat);
            REG_MASK: rd_mux = DATA_W'(irq_mask);
            REG_DISP: rd_mux = DATA_W'({disp[rd_dec.idx], 1'b0});
            default: rd_mux = '0;
        endcase
    end

    // Read data channel
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else begin
            if (rd_go) begin
                rvalid <= 1'b1;
                rdata <= rd_mux;
                rresp <= (rd_dec.kind == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (rvalid && axi_req_i.rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // Register write enables per kind
    assign wr_flag = wr_go && (wr_dec.kind == REG_FLAG);
    assign wr_enab = wr_go && (wr_dec.kind == REG_ENAB);
    assign wr_mask = wr_go && (wr_dec.kind == REG_MASK);

    // Flag set by enabled peripheral event, regardless of interrupt enable
    assign flag_set = src_evt_i & periph_en_i;

    // Interrupt flags; sticky until cleared by software, event wins
    ivob_alias_reg #(
        .W(NSRC),
        .RST(FLAG_RST)
    ) u_flag (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .wr_i(wr_flag),
        .op_i(wr_dec.op),
        .wdata_i(w_data[NSRC-1:0]),
        .wmask_i(wmask[NSRC-1:0]),
        .hw_set_i(flag_set),
        .q_o(int_flag_o)
    );

    // Interrupt enables
    ivob_alias_reg #(
        .W(NSRC),
        .RST(ENAB_RST)
    ) u_enab (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .wr_i(wr_enab),
        .op_i(wr_dec.op),
        .wdata_i(w_data[NSRC-1:0]),
        .wmask_i(wmask[NSRC-1:0]),
        .hw_set_i('0),
        .q_o(int_enab)
    );

    // Interrupt output mask
    ivob_alias_reg #(
        .W(NSRC),
        .RST(MASK_RST)
    ) u_mask (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .wr_i(wr_mask),
        .op_i(wr_dec.op),
        .wdata_i(w_data[NSRC-1:0]),
        .wmask_i(wmask[NSRC-1:0]),
        .hw_set_i('0),
        .q_o(irq_mask)
    );

    // Sticky status of enabled source events, cleared by its read
    assign stat_set = flag_set & int_enab;
    assign stat_clr = (rd_go && rd_dec.kind == REG_STAT) ? '1 : '0;
    assign wr_stat = wr_go && (wr_dec.kind == REG_STAT);
    assign stat_bits = w_data[NSRC-1:0] & wmask[NSRC-1:0];

    // Read clear, then software alias write, hardware set wins last
    always_comb begin
        next_stat = irq_stat & ~stat_clr;
        if (wr_stat) begin
            unique case (wr_dec.op)
                ALIAS_DIR: next_stat = (next_stat & ~wmask[NSRC-1:0]) | stat_bits;
                ALIAS_CLR: next_stat = next_stat & ~stat_bits;
                ALIAS_SET: next_stat = next_stat | stat_bits;
                ALIAS_INV: next_stat = next_stat ^ stat_bits;
            endcase
        end
        next_stat = next_stat | stat_set;
    end

    // Status storage
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_stat <= STAT_RST;
        end else begin
            irq_stat <= next_stat;
        end
    end

    // Level interrupt while any unmasked status bit is set
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat & irq_mask);
        end
    end

    // Displacement bank, direct writes only, field bits 17..1
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < NDISP; i++) begin
                disp[i] <= DISP_RST;
            end
        end else begin
            if (wr_go && wr_dec.kind == REG_DISP) begin
                disp[wr_dec.idx] <= (disp[wr_dec.idx] & ~wmask[DISP_MSB:DISP_LSB])
                    | (w_data[DISP_MSB:DISP_LSB] & wmask[DISP_MSB:DISP_LSB]);
            end
        end
    end

    // Offset lookup for the controller, zero for an out-of-range index
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            disp_off_o <= '0;
        end else begin
            if (disp_sel_i < 4'(NDISP)) begin
                disp_off_o <= DATA_W'({disp[disp_sel_i], 1'b0});
            end else begin
                disp_off_o <= '0;
            end
        end
    end

    // Bus answer assembled from channel flops
    assign axi_rsp_o.awready = awready;
    assign axi_rsp_o.wready = wready;
    assign axi_rsp_o.bvalid = bvalid;
    assign axi_rsp_o.bresp = bresp;
    assign axi_rsp_o.arready = arready;
    assign axi_rsp_o.rvalid = rvalid;
    assign axi_rsp_o.rdata = rdata;
    assign axi_rsp_o.rresp = rresp;

endmodule : ivob_bank

`default_nettype wire

/* File: verification/ivob_bank_props.sv */
`timescale 1ns/10ps
`default_nettype none

module ivob_bank_props (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire ivob_pkg::ivob_axi_req_t axi_req_i,
    input wire ivob_pkg::ivob_axi_rsp_t axi_rsp_o,
    input wire logic [ivob_pkg::NSRC-1:0] src_evt_i,
    input wire logic [ivob_pkg::NSRC-1:0] periph_en_i,
    input wire logic [3:0] disp_sel_i,
    input wire logic [ivob_pkg::DATA_W-1:0] disp_off_o,
    input wire logic [ivob_pkg::NSRC-1:0] int_flag_o,
    input wire logic irq_o
);
    import ivob_pkg::*;

    logic [NSRC-1:0] hit_q;

    // Qualified events seen at the last edge
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hit_q <= '0;
        end else begin
            hit_q <= src_evt_i & periph_en_i;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    // Software change shows with its write answer
    sequence wr_answer_s;
        ##[0:1] axi_rsp_o.bvalid;
    endsequence

    sequence rd_answer_s;
        ##[1:3] axi_rsp_o.rvalid;
    endsequence

    chk_flag_set: assert property ((int_flag_o & hit_q) == hit_q)
        else $error("flag missed a qualified event");
    chk_flag_swset: assert property (
        (int_flag_o & ~$past(int_flag_o) & ~hit_q) != '0 |-> wr_answer_s)
        else $error("flag rose without event or write");
    chk_flag_hold: assert property (
        ($past(int_flag_o) & ~int_flag_o) != '0 |-> wr_answer_s)
        else $error("flag fell without a write");
    chk_read_answer: assert property (
        axi_req_i.arvalid && axi_rsp_o.arready |-> rd_answer_s)
        else $error("read not answered");
    chk_read_hold: assert property (
        axi_rsp_o.rvalid && !axi_req_i.rready |=> axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata))
        else $error("read data dropped early");
    chk_read_upper: assert property (
        axi_rsp_o.rvalid |-> axi_rsp_o.rdata[31:18] == '0)
        else $error("unimplemented bits read nonzero");
    chk_disp_format: assert property (
        disp_off_o[0] == 1'b0 && disp_off_o[31:18] == '0)
        else $error("offset outside field");
    chk_disp_none: assert property (disp_sel_i >= 4'he |=> disp_off_o == '0)
        else $error("offset for empty index");
endmodule : ivob_bank_props

`default_nettype wire

/* File: verification/ivob_periph_model.sv */
`timescale 1ns/10ps
`default_nettype none

module ivob_periph_model (
    input wire logic clk_i,
    output logic [ivob_pkg::NSRC-1:0] evt_o,
    output logic [ivob_pkg::NSRC-1:0] en_o
);
    import ivob_pkg::*;

    // Peripherals idle and off
    initial begin
        evt_o = '0;
        en_o = '0;
    end

    // One-cycle event from a peripheral that is on or off
    task automatic fire(input int idx, input logic on);
        @(posedge clk_i);
        en_o[idx] <= on;
        evt_o[idx] <= 1'b1;
        @(posedge clk_i);
        evt_o[idx] <= 1'b0;
        en_o[idx] <= 1'b0;
    endtask : fire
endmodule : ivob_periph_model

`default_nettype wire

/* File: verification/ivob_bank_bench.sv */
`timescale 1ns/10ps
`default_nettype none

module ivob_bank_bench;
    import ivob_pkg::*;

    logic clk_i;
    logic arst_n_i;
    ivob_axi_req_t req;
    ivob_axi_rsp_t rsp;
    logic [NSRC-1:0] evt;
    logic [NSRC-1:0] en;
    logic [3:0] disp_sel_i;
    logic [DATA_W-1:0] disp_off_o;
    logic [NSRC-1:0] int_flag_o;
    logic irq_o;
    int n_errors = 0;
    int total_checks = 0;
    logic [31:0] ev;
    int rd_lag = 0;
    logic [3:0] wr_strb = 4'hf;
    logic [11:0] bases [3] = '{OFF_FLAG, OFF_ENAB, OFF_MASK};
    logic [1:0] ops [5] = '{ALIAS_DIR, ALIAS_CLR, ALIAS_SET, ALIAS_INV, ALIAS_CLR};
    logic [31:0] pats [5] = '{32'hffff_ffff, 32'hffff_ffff, 32'hffff_00f0, 32'h0000_0018,
        32'h0000_0081};

    ivob_bank dut (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .axi_req_i(req),
        .axi_rsp_o(rsp),
        .src_evt_i(evt),
        .periph_en_i(en),
        .disp_sel_i(disp_sel_i),
        .disp_off_o(disp_off_o),
        .int_flag_o(int_flag_o),
        .irq_o(irq_o)
    );

    ivob_periph_model u_periph (.clk_i(clk_i), .evt_o(evt), .en_o(en));

    // Clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    // Bus write, both channels offered together
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_i);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= wr_strb;
        req.bready <= 1'b1;
        forever begin
            @(posedge clk_i);
            n++;
            if (req.awvalid && rsp.awready)
                req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready)
                req.wvalid <= 1'b0;
            if (rsp.bvalid || n > 100) begin
                if (n > 100)
                    n_errors++;
                req.bready <= 1'b0;
                check(32'(rsp.bresp), 32'(er));
                break;
            end
        end
    endtask : wr

    // Bus read
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_i);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= (rd_lag == 0);
        forever begin
            @(posedge clk_i);
            n++;
            if (req.arvalid && rsp.arready)
                req.arvalid <= 1'b0;
            if ((rsp.rvalid && req.rready) || n > 100) begin
                if (n > 100)
                    n_errors++;
                req.rready <= 1'b0;
                check(rsp.rdata, ed);
                check(32'(rsp.rresp), 32'(er));
                break;
            end
            // Late ready keeps the answer waiting for a few edges
            if (n >= rd_lag)
                req.rready <= 1'b1;
        end
    endtask : rd

    // Hang guard
    initial begin
        #(100 * 30000);
        n_errors++;
        test_done();
    end

    // Main sequence
    initial begin
        arst_n_i = 1'b0;
        req = '0;
        disp_sel_i = 4'h0;
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        for (int i = 0; i < NDISP; i++)
            rd(DISP_OFF[i], 32'h0, RESP_OKAY);
        for (int i = 0; i < NDISP; i++)
            wr(DISP_OFF[i], 32'hffff_ffff ^ (32'(i) << 4), RESP_OKAY);
        for (int i = 0; i < NDISP; i++) begin
            ev = (32'hffff_ffff ^ (32'(i) << 4)) & 32'h0003_fffe;
            rd(DISP_OFF[i], ev, RESP_OKAY);
            disp_sel_i <= i[3:0];
            repeat (3) @(posedge clk_i);
            check(disp_off_o, ev);
        end
        disp_sel_i <= 4'he;
        repeat (3) @(posedge clk_i);
        check(disp_off_o, 32'h0);
        $display("test displacement done");
        wr(12'h60c, 32'h0, RESP_SLVERR);
        wr(12'h624, 32'h0, RESP_SLVERR);
        rd(12'h610, 32'h0, RESP_SLVERR);
        rd(12'h608, (32'hffff_ffff ^ 32'h90) & 32'h0003_fffe, RESP_OKAY);
        rd(12'h620, (32'hffff_ffff ^ 32'hd0) & 32'h0003_fffe, RESP_OKAY);
        $display("test no alias done");
        u_periph.fire(3, 1'b1);
        rd(OFF_FLAG, 32'h8, RESP_OKAY);
        u_periph.fire(5, 1'b0);
        repeat (20) @(posedge clk_i);
        rd(OFF_FLAG, 32'h8, RESP_OKAY);
        rd_lag = 4;
        rd(OFF_FLAG, 32'h8, RESP_OKAY);
        rd_lag = 0;
        $display("test flags done");
        foreach (bases[b]) begin
            ev = 32'h0;
            for (int k = 0; k < 5; k++) begin
                wr(bases[b] + {8'h0, ops[k], 2'h0}, pats[k], RESP_OKAY);
                case (ops[k])
                    ALIAS_DIR: ev = pats[k];
                    ALIAS_CLR: ev = ev & ~pats[k];
                    ALIAS_SET: ev = ev | pats[k];
                    default: ev = ev ^ pats[k];
                endcase
                ev = ev & 32'h0000_ffff;
                rd(bases[b], ev, RESP_OKAY);
            end
        end
        check(32'(int_flag_o), 32'h68);
        wr_strb = 4'h2;
        wr(OFF_ENAB, 32'hffff_ffff, RESP_OKAY);
        wr_strb = 4'hf;
        rd(OFF_ENAB, 32'h0000_ff68, RESP_OKAY);
        $display("test aliases done");
        u_periph.fire(3, 1'b1);
        repeat (3) @(posedge clk_i);
        check(32'(irq_o), 32'h1);
        rd(OFF_STAT, 32'h8, RESP_OKAY);
        rd(OFF_STAT, 32'h0, RESP_OKAY);
        repeat (2) @(posedge clk_i);
        check(32'(irq_o), 32'h0);
        wr(OFF_MASK + 12'h4, 32'h8, RESP_OKAY);
        u_periph.fire(3, 1'b1);
        repeat (3) @(posedge clk_i);
        check(32'(irq_o), 32'h0);
        rd(OFF_STAT, 32'h8, RESP_OKAY);
        check(32'(int_flag_o), 32'h68);
        wr(OFF_STAT + 12'h8, 32'h20, RESP_OKAY);
        repeat (2) @(posedge clk_i);
        check(32'(irq_o), 32'h1);
        wr(OFF_STAT + 12'h4, 32'h20, RESP_OKAY);
        repeat (2) @(posedge clk_i);
        check(32'(irq_o), 32'h0);
        wr(OFF_STAT + 12'hc, 32'h40, RESP_OKAY);
        rd(OFF_STAT, 32'h40, RESP_OKAY);
        $display("test interrupt done");
        arst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        rd(DISP_OFF[0], 32'h0, RESP_OKAY);
        rd(OFF_FLAG, 32'h0, RESP_OKAY);
        $display("test second reset done");
        test_done();
    end
endmodule : ivob_bank_bench

bind ivob_bank ivob_bank_props u_props (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .axi_req_i(axi_req_i),
    .axi_rsp_o(axi_rsp_o),
    .src_evt_i(src_evt_i),
    .periph_en_i(periph_en_i),
    .disp_sel_i(disp_sel_i),
    .disp_off_o(disp_off_o),
    .int_flag_o(int_flag_o),
    .irq_o(irq_o)
);

`default_nettype wire
